// [core/ppp_pkg.sv]
// Constants and types for the parallel peripheral port host.
// ==========================================================
// Behaviour
// - The port carries one byte on eight two-way data lines, line 7 being the most significant bit.
// - The host drives the direction line high while it expects the peripheral to put data on the lines.
// - The host drives the direction line low while it outputs data toward the peripheral.
// - Whoever drives the data lines also drives the parity line so that byte plus parity has odd parity.
// - The host asserts the active-low strobe to mark valid output data on the lines.
// - The host asserts the active-low command marker when the byte it presents is a command.
// - The host watches the sense line and takes a high level as no peripheral attached.
// - The host asserts the active-low peripheral reset when the peripheral must return to power-on state.
// - The peripheral may signal a fault on the check line and the host can route it to a processor interrupt.
package ppp_pkg;
  // ==========================================================
  // Timing.
  localparam int CLK_PERIOD_NS    = 100;
  localparam int SETUP_NS         = 200;
  localparam int STROBE_NS        = 300;
  localparam int RESET_PULSE_NS   = 1000;
  localparam int SETUP_CYC        = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC       = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CYC        = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W            = 8;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // Synchroniser reset matches the pins' idle levels: not busy, no device until seen.
  localparam logic [11:0] SYNC_RST = 12'h600;

  // ==========================================================
  // Sequencer states.
  typedef enum logic [2:0] {
    PPP_IDLE   = 3'b000,
    PPP_SETUP  = 3'b001,
    PPP_STROBE = 3'b010,
    PPP_RSETUP = 3'b011,
    PPP_RSTRB  = 3'b100,
    PPP_PRST   = 3'b101
  } ppp_state_e;
endpackage

// [core/ppp_host.sv]
// Host end of the parallel peripheral port with a two-entry receive buffer.
`timescale 1ns/1ps
module ppp_host
  import ppp_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       wr_valid,
  output logic            wr_ready,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_cmd,
  input  wire logic       rd_req,
  output logic            rd_valid,
  input  wire logic       rd_ready,
  output logic [7:0]      rd_data,
  output logic            rd_parity_err,
  input  wire logic       reset_req,
  input  wire logic       fault_irq_en,
  output logic            fault_irq,
  output logic            device_absent,
  output logic            peripheral_busy,
  input  wire logic [7:0] peripheral_data_lines_i,
  output logic [7:0]      peripheral_data_lines_o,
  output logic            peripheral_data_lines_oe_n,
  input  wire logic       parity_i,
  output logic            parity_o,
  output logic            parity_oe_n,
  output logic            direction,
  output logic            strobe_n,
  output logic            command_n,
  input  wire logic       peripheral_busy_n,
  input  wire logic       no_device_sense,
  output logic            peripheral_reset_n,
  input  wire logic       peripheral_fault
);
  import ppp_pkg::*;

  // ==========================================================
  // Pin synchronisers.
  logic [11:0] s1_q;
  logic [11:0] s2_q;
  wire  [11:0] pins_in = {peripheral_fault, no_device_sense, peripheral_busy_n, parity_i, peripheral_data_lines_i};
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
    end else begin
      s1_q <= pins_in;
      s2_q <= s1_q;
    end
  end
  wire [7:0] din_s    = s2_q[7:0];
  wire       par_s    = s2_q[8];
  wire       busy_s   = ~s2_q[9];
  wire       absent_s = s2_q[10];
  wire       fault_s  = s2_q[11];

  // ==========================================================
  // Two-entry receive buffer.
  logic [7:0] buf_q [2];
  logic [1:0] perr_q;
  logic       wp_q;
  logic       rp_q;
  logic [1:0] cnt_q;
  wire        buf_full  = (cnt_q == 2'h2);
  wire        buf_empty = (cnt_q == 2'h0);
  logic       push;
  wire        pop       = rd_valid & rd_ready;
  wire        rx_perr   = ~^{din_s, par_s};  // Even count of ones is a parity fault.

  // ==========================================================
  // Sequencer.
  ppp_state_e state_q;
  ppp_state_e state_d;
  logic [CNT_W-1:0] tmr_q;
  logic [CNT_W-1:0] tmr_d;
  logic [7:0] dout_q;
  logic       cmd_q;
  wire        tmr_done = (tmr_q == '0);
  wire        can_go   = ~busy_s & ~absent_s;  // Never start a transfer toward a busy or missing peripheral.

  always_comb begin
    state_d = state_q;
    tmr_d   = tmr_done ? tmr_q : tmr_q - CNT_W'(1);
    push    = 1'b0;
    case (state_q)
      PPP_IDLE: begin
        if (reset_req) begin
          state_d = PPP_PRST;
          tmr_d   = CNT_W'(RESET_CYC);
        end else if (wr_valid && can_go) begin
          state_d = PPP_SETUP;
          tmr_d   = CNT_W'(SETUP_CYC);
        end else if (rd_req && can_go && !buf_full) begin
          state_d = PPP_RSETUP;
          tmr_d   = CNT_W'(SETUP_CYC);
        end
      end
      PPP_SETUP: if (tmr_done) begin
        state_d = PPP_STROBE;
        tmr_d   = CNT_W'(STROBE_CYC);
      end
      PPP_STROBE: if (tmr_done) state_d = PPP_IDLE;
      PPP_RSETUP: if (tmr_done) begin
        state_d = PPP_RSTRB;
        tmr_d   = CNT_W'(STROBE_CYC);
      end
      PPP_RSTRB: if (tmr_done) begin
        state_d = PPP_IDLE;
        push    = 1'b1;
      end
      PPP_PRST: if (tmr_done) state_d = PPP_IDLE;
      default: state_d = PPP_IDLE;
    endcase
  end

  wire take_wr = (state_q == PPP_IDLE) && !reset_req && wr_valid && can_go;
  wire out_ph  = (state_d == PPP_SETUP) || (state_d == PPP_STROBE);
  wire in_ph   = (state_d == PPP_RSETUP) || (state_d == PPP_RSTRB);
  wire [7:0] dout_d = take_wr ? wr_data : dout_q;
  wire cmd_d   = take_wr ? wr_cmd : cmd_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= PPP_IDLE;
      tmr_q   <= '0;
      dout_q  <= BYTE_RST;
      cmd_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      tmr_q   <= tmr_d;
      dout_q  <= dout_d;
      cmd_q   <= cmd_d;
    end
  end

  // ==========================================================
  // Pin outputs, all registered.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      peripheral_data_lines_o    <= BYTE_RST;
      peripheral_data_lines_oe_n <= 1'b1;
      parity_o                   <= 1'b1;
      parity_oe_n                <= 1'b1;
      direction                  <= 1'b1;
      strobe_n                   <= 1'b1;
      command_n                  <= 1'b1;
      peripheral_reset_n         <= 1'b1;
    end else begin
      peripheral_data_lines_o    <= dout_d;
      peripheral_data_lines_oe_n <= ~out_ph;
      parity_o                   <= ~^dout_d;
      parity_oe_n                <= ~out_ph;
      direction                  <= ~out_ph;
      strobe_n                   <= ~((state_d == PPP_STROBE) || (state_d == PPP_RSTRB));
      command_n                  <= ~(out_ph & cmd_d);
      peripheral_reset_n         <= ~(state_d == PPP_PRST);
    end
  end

  // ==========================================================
  // Buffer storage and status outputs.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      buf_q[0] <= BYTE_RST;
      buf_q[1] <= BYTE_RST;
      perr_q   <= 2'h0;
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      if (push) begin
        buf_q[wp_q]  <= din_s;
        perr_q[wp_q] <= rx_perr;
        wp_q         <= ~wp_q;
      end
      if (pop) rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // The buffer head is read combinationally from the next read pointer into registered outputs, so a
  // pop advances the pointer and the next word appears on the same edge that takes the pop.
  wire [1:0] cnt_n  = cnt_q + {1'b0, push} - {1'b0, pop};
  wire       rp_n   = pop ? ~rp_q : rp_q;
  // The entry being written this edge still holds its old value, so bypass it.
  wire       head_wr = push && (rp_n == wp_q);
  wire [7:0] head_d  = head_wr ? din_s : buf_q[rp_n];
  wire       hperr   = head_wr ? rx_perr : perr_q[rp_n];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rd_valid        <= 1'b0;
      rd_data         <= BYTE_RST;
      rd_parity_err   <= 1'b0;
      wr_ready        <= 1'b0;
      fault_irq       <= 1'b0;
      device_absent   <= 1'b1;
      peripheral_busy <= 1'b0;
    end else begin
      rd_valid        <= (cnt_n != 2'h0);
      rd_data         <= head_d;
      rd_parity_err   <= hperr;
      wr_ready        <= take_wr;
      fault_irq       <= fault_s & fault_irq_en;
      device_absent   <= absent_s;
      peripheral_busy <= busy_s;
    end
  end
endmodule

// [tb/ppp_checker.sv]
// Checker of the host port's pin behaviour.
`timescale 1ns/1ps
module ppp_checker (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       wr_ready,
  input wire logic       direction,
  input wire logic       strobe_n,
  input wire logic       command_n,
  input wire logic       peripheral_data_lines_oe_n,
  input wire logic [7:0] peripheral_data_lines_o,
  input wire logic       parity_oe_n,
  input wire logic       parity_o,
  input wire logic       peripheral_busy,
  input wire logic       peripheral_busy_n,
  input wire logic       device_absent,
  input wire logic       peripheral_reset_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // Properties.
  sequence s_take; wr_ready && !direction; endsequence
  sequence s_strobe; ##3 !strobe_n; endsequence
  property p_walk; s_take |-> s_strobe; endproperty
  a_walk: assert property (p_walk) else $error("strobe late");
  property p_out; !peripheral_data_lines_oe_n |-> !direction; endproperty
  a_out: assert property (p_out) else $error("direction high");
  property p_odd; !parity_oe_n |-> ^{peripheral_data_lines_o, parity_o}; endproperty
  a_odd: assert property (p_odd) else $error("parity even");
  property p_hold; !strobe_n && !direction |-> $stable(peripheral_data_lines_o); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_cmd; !command_n |-> !peripheral_data_lines_oe_n; endproperty
  a_cmd: assert property (p_cmd) else $error("marker alone");
  property p_busy; wr_ready |-> !peripheral_busy && !device_absent; endproperty
  a_busy: assert property (p_busy) else $error("taken busy");
  property p_sync; !peripheral_busy_n [*4] |-> peripheral_busy; endproperty
  a_sync: assert property (p_sync) else $error("busy unseen");
  property p_rst; $fell(peripheral_reset_n) |-> !peripheral_reset_n [*8]; endproperty
  a_rst: assert property (p_rst) else $error("reset short");
endmodule

// [tb/ppp_periph.sv]
// Behavioural peripheral on the far side of the port.
`timescale 1ns/1ps
module ppp_periph (
  input wire logic       clk_sys,
  input wire logic [7:0] host_o,
  input wire logic       host_p,
  input wire logic       host_oe_n,
  input wire logic       strobe_n,
  input wire logic       command_n,
  input wire logic [7:0] send,
  input wire logic       bad_par,
  output logic     [7:0] lines,
  output logic           par,
  output logic     [7:0] got,
  output logic           got_cmd
);
  // The far side drives whenever the host lets go, so the lines never float.
  assign lines = host_oe_n ? send : host_o;
  assign par   = host_oe_n ? (~^send ^ bad_par) : host_p;
  always @(posedge clk_sys) begin
    if (!strobe_n && !host_oe_n) begin
      got     <= lines;
      got_cmd <= !command_n;
    end
  end
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the parallel port host.
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 0, nrst = 0, wr_valid = 0, wr_cmd = 0, rd_req = 0, rd_ready = 0;
  logic reset_req = 0, fault_irq_en = 0, peripheral_busy_n = 1, no_device_sense = 0;
  logic peripheral_fault = 0, bad_par = 0, parity_i, parity_o, parity_oe_n, got_cmd;
  logic wr_ready, rd_valid, rd_parity_err, fault_irq, device_absent, peripheral_busy;
  logic direction, strobe_n, command_n, peripheral_reset_n, peripheral_data_lines_oe_n;
  logic [7:0] wr_data = 8'h00, send = 8'h00, rd_data, got;
  logic [7:0] peripheral_data_lines_i, peripheral_data_lines_o;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  ppp_host i_ppp_host (.*);
  ppp_periph i_ppp_periph (.clk_sys(clk_sys), .host_o(peripheral_data_lines_o), .host_p(parity_o),
    .host_oe_n(peripheral_data_lines_oe_n), .strobe_n(strobe_n), .command_n(command_n), .send(send),
    .bad_par(bad_par), .lines(peripheral_data_lines_i), .par(parity_i), .got(got), .got_cmd(got_cmd));
  always #50 clk_sys = ~clk_sys;
  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic t_write(input logic [7:0] d, input logic c);
    int i;
    wr_data = d;
    wr_cmd = c;
    wr_valid = 1;
    for (i = 0; i < 40 && wr_ready !== 1'b1; i++) tick(1);
    wr_valid = 0;
    chk(i < 40, 1);
    tick(8);
    chk(got, d);
    chk(got_cmd, c);
  endtask
  task automatic t_busy();
    peripheral_busy_n = 0;
    tick(4);
    chk(peripheral_busy, 1);
    wr_valid = 1;
    repeat (10) begin
      tick(1);
      chk(wr_ready, 0);
    end
    peripheral_busy_n = 1;
    t_write(8'h3C, 0);
  endtask
  task automatic t_read(input logic [7:0] d, input logic bad);
    int i;
    send = d;
    bad_par = bad;
    rd_req = 1;
    tick(1);
    rd_req = 0;
    for (i = 0; i < 40 && rd_valid !== 1'b1; i++) tick(1);
    chk(rd_data, d);
    chk(rd_parity_err, bad);
    rd_ready = 1;
    tick(1);
    rd_ready = 0;
    chk(rd_valid, 0);
  endtask
  task automatic t_fill();
    send = 8'h5A;
    bad_par = 0;
    rd_req = 1;
    tick(40);
    rd_req = 0;
    repeat (2) begin
      chk({rd_valid, rd_data[6:0]}, 8'hDA);
      rd_ready = 1;
      tick(1);
      rd_ready = 0;
    end
    tick(2);
    chk(rd_valid, 0);
  endtask
  task automatic t_pins();
    reset_req = 1;
    tick(1);
    reset_req = 0;
    tick(3);
    chk(peripheral_reset_n, 0);
    tick(12);
    chk(peripheral_reset_n, 1);
    no_device_sense = 1;
    peripheral_fault = 1;
    fault_irq_en = 1;
    tick(4);
    chk(device_absent, 1);
    chk(fault_irq, 1);
    fault_irq_en = 0;
    no_device_sense = 0;
    tick(4);
    chk(fault_irq, 0);
    chk(device_absent, 0);
  endtask
  initial begin
    tick(2);
    nrst = 1;
    tick(3);
    chk(direction, 1);
    t_write(8'h80, 0);
    t_write(8'h01, 1);
    t_busy();
    t_read(8'hA5, 0);
    t_read(8'h37, 1);
    t_fill();
    t_pins();
    give_verdict();
  end
endmodule
bind ppp_host ppp_checker i_ppp_checker (.*);
